// >>> src/pcs_ctrl_pkg.sv
/*
 Package for the SGMII/1000BASE-X TBI control block: register indices,
 field positions, reset values and link timer figures.
 Assumes a 40 MHz core clock and an Avalon-MM register slave.
*/
package pcs_ctrl_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [15:0] NEG_CTRL_IDX    = 16'hd304;
    localparam logic [15:0] TBI_CTRL_IDX    = 16'hd305;
    localparam logic [15:0] TX_WORD_HI_IDX  = 16'hd300;
    localparam logic [15:0] TX_WORD_LO_IDX  = 16'hd301;
    localparam logic [15:0] STATUS_IDX      = 16'hd3f0;

    // ==========================================================
    // Reset values
    localparam logic [15:0] NEG_CTRL_RST    = 16'h00b2;
    localparam logic [7:0]  TBI_CTRL_RST    = 8'h01;

    // ==========================================================
    // Negotiation control field positions
    localparam int NC_LT_LO     = 0;
    localparam int NC_ENABLE    = 2;
    localparam int NC_RESTART   = 3;
    localparam int NC_ABL_OVR   = 4;
    localparam int NC_CTL_OVR   = 5;
    localparam int NC_MODE_LO   = 6;
    localparam int NC_BCOMP     = 15;

    // TBI control field positions
    localparam int TC_INIT      = 0;
    localparam int TC_ENABLE    = 1;
    localparam int TC_LOOPBACK  = 2;
    localparam int TC_REPEATER  = 3;
    localparam int TC_EXTEND    = 4;
    localparam int TC_CRS_OFF   = 5;
    localparam int TC_IN_REV    = 6;
    localparam int TC_OUT_REV   = 7;

    // ==========================================================
    // Negotiation protocols
    typedef enum logic [1:0] {
        PROTO_RESERVED = 2'b00,
        PROTO_BASEX    = 2'b01,
        PROTO_SGMII_PHY = 2'b10,
        PROTO_SGMII_MAC = 2'b11
    } proto_t;

    // ==========================================================
    // Link timer figures
    localparam int CLK_HZ        = 40_000_000;
    localparam int T_SIM_US      = 10;
    localparam int T_SGMII_US    = 1600;
    localparam int T_MID_US      = 5000;
    localparam int T_TBI_US      = 10000;
    localparam int T_SIM_CYC     = T_SIM_US * (CLK_HZ / 1_000_000);
    localparam int T_SGMII_CYC   = T_SGMII_US * (CLK_HZ / 1_000_000);
    localparam int T_MID_CYC     = T_MID_US * (CLK_HZ / 1_000_000);
    localparam int T_TBI_CYC     = T_TBI_US * (CLK_HZ / 1_000_000);

    // Code group K28.5, positive disparity-neutral comma detection pattern
    localparam logic [6:0]  COMMA_PAT    = 7'h7c;
    localparam logic [9:0]  CG_T_RDN     = 10'h2e8;
    localparam logic [9:0]  CG_T_RDP     = 10'h117;
    localparam logic [9:0]  CG_R_RDN     = 10'h3a8;
    localparam logic [9:0]  CG_R_RDP     = 10'h057;

endpackage : pcs_ctrl_pkg

// >>> src/pcs_ctrl.sv
/*
 TBI physical coding sublayer control: ability word source, negotiation
 control with link timer, code group bit-order reversal, loopback, carrier
 sense generation and FSM enable / init gating.
 Assumes an Avalon-MM master on CLK and code groups aligned to CLK.
*/
// Notes on behaviour
// (R01) SGMII PHY ability from duplex, speed inputs
// (R02) 1000BASE-X ability from duplex, pause, fault
// (R03) Override takes word from software registers
// (R04) Restart bit restarts FSM, self clears
// (R05) Enable bit switches auto-negotiation
// (R06) Link timer select picks four delays
// (R07) Output reverse flips encoder code group
// (R08) Input reverse flips decoder code group
// (R09) Carrier sense disable forces CRS low
// (R10) Extension select extends on T R R comma
// (R11) Repeater mode: CRS only on receive
// (R12) Loopback bit enables digital TBI loopback
// (R13) Software must also enable PMA loops
// (R14) Interface enable zero freezes TBI FSMs
// (R15) Init bit holds FSMs, resets to one
// (R16) Control override selects pin or register controls
// (R17) Protocol field selects BASE-X or SGMII role
// (R18) Register writes accepted while frozen or init
`timescale 1ns/10ps
`default_nettype none

module pcs_ctrl
    import pcs_ctrl_pkg::*;
#(
    parameter int SIM_CYC   = T_SIM_CYC,
    parameter int SGMII_CYC = T_SGMII_CYC,
    parameter int MID_CYC   = T_MID_CYC,
    parameter int TBI_CYC   = T_TBI_CYC
)(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // Avalon-MM slave
    input  wire logic [17:0] AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic      [1:0]  AVS_RESPONSE,
    // Ability and negotiation control pins
    input  wire logic        FULL_DUPLEX_ABILITY_IN,
    input  wire logic        HALF_DUPLEX_ABILITY_IN,
    input  wire logic        SPEED_ABILITY_IN,
    input  wire logic        PAUSE_ABILITY_IN,
    input  wire logic        REMOTE_FAULT_IN,
    input  wire logic [1:0]  PROTOCOL_IN,
    input  wire logic        NEG_ENABLE_IN,
    input  wire logic        NEG_RESTART_IN,
    // Negotiation engine side
    input  wire logic        NEG_FSM_RESTARTED,
    output logic      [15:0] TX_CONFIG_WORD,
    output logic      [1:0]  NEG_PROTOCOL,
    output logic             NEG_ENABLE,
    output logic             NEG_RESTART,
    output logic             NEG_LINK_TIMER_DONE,
    output logic             NEG_BACKCOMPAT,
    // Code groups
    input  wire logic [9:0]  ENC_CODE_GROUP,
    input  wire logic [9:0]  PMA_RX_CODE_GROUP,
    output logic      [9:0]  PMA_TX_CODE_GROUP,
    output logic      [9:0]  DEC_CODE_GROUP,
    // Carrier sense
    input  wire logic        TX_ACTIVE,
    input  wire logic        RX_ACTIVE,
    output logic             GMII_CRS,
    // FSM gating
    output logic             FSM_RUN,
    output logic             FSM_INIT,
    output logic             LOOPBACK_EN
);

    // ==========================================================
    // Registers
    logic [15:0] neg_ctrl_q;
    logic [7:0]  tbi_ctrl_q;
    logic [15:0] tx_word_q;
    logic [7:0]  tx_word_hi_stage_q;
    logic [15:0] addr_idx;
    logic        ack_q, wr_en;
    logic        sel_neg, sel_tbi, sel_hi, sel_lo, sel_stat;

    assign addr_idx = AVS_ADDRESS[17:2];
    assign sel_neg  = (addr_idx == NEG_CTRL_IDX);
    assign sel_tbi  = (addr_idx == TBI_CTRL_IDX);
    assign sel_hi   = (addr_idx == TX_WORD_HI_IDX);
    assign sel_lo   = (addr_idx == TX_WORD_LO_IDX);
    assign sel_stat = (addr_idx == STATUS_IDX);

    // One wait cycle per access; answer on the second edge
    always_ff @(posedge CLK)
    begin
        ack_q <= !RESET && !ack_q && (AVS_READ || AVS_WRITE);
    end
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
    assign wr_en = AVS_WRITE && ack_q; // writes land regardless of FSM gating, see (R18)

    // Negotiation control; set of restart by software wins over the clear
    always_ff @(posedge CLK)
    begin
        if (RESET)
            neg_ctrl_q <= NEG_CTRL_RST;
        else if (wr_en && sel_neg)
        begin
            if (AVS_BYTEENABLE[0])
                neg_ctrl_q[7:0] <= AVS_WRITEDATA[7:0];
            if (AVS_BYTEENABLE[1])
                neg_ctrl_q[15] <= AVS_WRITEDATA[15];
        end
        else if (NEG_FSM_RESTARTED)
            neg_ctrl_q[NC_RESTART] <= 1'b0; // see (R04)
    end

    // TBI control, reset with init asserted
    always_ff @(posedge CLK)
    begin
        if (RESET)
            tbi_ctrl_q <= TBI_CTRL_RST; // see (R15)
        else if (wr_en && sel_tbi && AVS_BYTEENABLE[0])
            tbi_ctrl_q <= AVS_WRITEDATA[7:0]; // see (R18)
    end

    // Software ability word: high byte staged, low byte write commits both
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            tx_word_q          <= 16'h0000;
            tx_word_hi_stage_q <= 8'h00;
        end
        else if (wr_en && sel_hi && AVS_BYTEENABLE[0])
            tx_word_hi_stage_q <= AVS_WRITEDATA[7:0];
        else if (wr_en && sel_lo && AVS_BYTEENABLE[0])
            tx_word_q <= {tx_word_hi_stage_q, AVS_WRITEDATA[7:0]};
    end

    // Read data, registered; unmapped reads zero with a slave error
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            AVS_READDATA <= 32'h0000_0000;
            AVS_RESPONSE <= 2'b00;
        end
        else if ((AVS_READ || AVS_WRITE) && !ack_q)
        begin
            AVS_RESPONSE <= (sel_neg || sel_tbi || sel_hi || sel_lo || sel_stat) ? 2'b00 : 2'b10;
            if (sel_neg)
                AVS_READDATA <= {16'h0000, neg_ctrl_q[15], 7'h00, neg_ctrl_q[7:0]};
            else if (sel_tbi)
                AVS_READDATA <= {24'h000000, tbi_ctrl_q};
            else if (sel_hi)
                AVS_READDATA <= {24'h000000, tx_word_hi_stage_q};
            else if (sel_lo)
                AVS_READDATA <= {24'h000000, tx_word_q[7:0]};
            else if (sel_stat)
                AVS_READDATA <= {28'h0000000, NEG_RESTART, NEG_ENABLE, NEG_PROTOCOL};
            else
                AVS_READDATA <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // Negotiation controls from pins or register
    logic       ctl_ovr;
    assign ctl_ovr   = neg_ctrl_q[NC_CTL_OVR]; // Register or synchronised pin controls, see (R16)
    assign NEG_BACKCOMPAT = neg_ctrl_q[NC_BCOMP];

    // Pins are asynchronous to CLK: two-flop synchronisers
    logic [4:0] ab_s1_q, ab_s2_q;
    logic [3:0] nc_s1_q, nc_s2_q;
    always_ff @(posedge CLK)
    begin
        ab_s1_q <= {FULL_DUPLEX_ABILITY_IN, HALF_DUPLEX_ABILITY_IN, SPEED_ABILITY_IN,
                    PAUSE_ABILITY_IN, REMOTE_FAULT_IN};
        ab_s2_q <= ab_s1_q;
        nc_s1_q <= {PROTOCOL_IN, NEG_ENABLE_IN, NEG_RESTART_IN};
        nc_s2_q <= nc_s1_q;
    end

    // Registered negotiation outputs
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            NEG_PROTOCOL <= PROTO_RESERVED;
            NEG_ENABLE   <= 1'b0;
            NEG_RESTART  <= 1'b0;
        end
        else
        begin
            NEG_PROTOCOL <= ctl_ovr ? neg_ctrl_q[NC_MODE_LO +: 2] : nc_s2_q[3:2]; // see (R17)
            NEG_ENABLE   <= ctl_ovr ? neg_ctrl_q[NC_ENABLE] : nc_s2_q[1]; // see (R05)
            NEG_RESTART  <= ctl_ovr ? neg_ctrl_q[NC_RESTART] : nc_s2_q[0]; // see (R04)
        end
    end

    // Ability word: duplex/speed for SGMII PHY, FD/HD/PS/RF for BASE-X
    logic [15:0] hw_word;
    always_comb
    begin
        hw_word = 16'h0000;
        if (NEG_PROTOCOL == PROTO_SGMII_PHY)
        begin
            hw_word[0]     = 1'b1;
            hw_word[12:11] = {ab_s2_q[4] && !ab_s2_q[3], ab_s2_q[2]}; // see (R01)
        end
        else if (NEG_PROTOCOL == PROTO_BASEX)
        begin
            hw_word[6:5]   = {ab_s2_q[3], ab_s2_q[4]}; // see (R02)
            hw_word[8:7]   = {2{ab_s2_q[1]}};
            hw_word[13:12] = {2{ab_s2_q[0]}};
        end
    end
    always_ff @(posedge CLK)
    begin
        if (RESET)
            TX_CONFIG_WORD <= 16'h0000;
        else
            TX_CONFIG_WORD <= neg_ctrl_q[NC_ABL_OVR] ? tx_word_q : hw_word; // see (R03)
    end

    // ==========================================================
    // Link timer; restarts with each negotiation restart
    logic [19:0] lt_cnt_q;
    logic [19:0] lt_limit;
    always_comb
    begin
        case (neg_ctrl_q[NC_LT_LO +: 2]) // see (R06)
            2'b00:   lt_limit = 20'(SIM_CYC - 1);
            2'b01:   lt_limit = 20'(SGMII_CYC - 1);
            2'b10:   lt_limit = 20'(MID_CYC - 1);
            default: lt_limit = 20'(TBI_CYC - 1);
        endcase
    end
    always_ff @(posedge CLK)
    begin
        if (RESET || NEG_RESTART || !NEG_ENABLE || !FSM_RUN)
        begin
            lt_cnt_q            <= 20'h00000;
            NEG_LINK_TIMER_DONE <= 1'b0;
        end
        else
        begin
            lt_cnt_q            <= (lt_cnt_q >= lt_limit) ? 20'h00000 : lt_cnt_q + 20'h00001;
            NEG_LINK_TIMER_DONE <= (lt_cnt_q >= lt_limit); // One-cycle pulse per period
        end
    end

    // ==========================================================
    // Code group paths; reverse via one generate loop
    logic [9:0] enc_rev, rx_rev, rx_src;
    generate
        for (genvar i = 0; i < 10; i++)
        begin : g_rev
            assign enc_rev[i] = ENC_CODE_GROUP[9 - i];
            assign rx_rev[i]  = rx_src[9 - i];
        end
    endgenerate

    // Loopback feeds the transmit group back to the decoder
    assign rx_src = tbi_ctrl_q[TC_LOOPBACK] ? PMA_TX_CODE_GROUP : PMA_RX_CODE_GROUP; // see (R12)
    assign LOOPBACK_EN = tbi_ctrl_q[TC_LOOPBACK]; // PMA loops must be set by software, see (R13)

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            PMA_TX_CODE_GROUP <= 10'h000;
            DEC_CODE_GROUP    <= 10'h000;
        end
        else
        begin
            PMA_TX_CODE_GROUP <= tbi_ctrl_q[TC_OUT_REV] ? enc_rev : ENC_CODE_GROUP; // see (R07)
            DEC_CODE_GROUP    <= tbi_ctrl_q[TC_IN_REV] ? rx_rev : rx_src; // see (R08)
        end
    end

    // FSM gating: init dominates, disable freezes
    assign FSM_INIT = tbi_ctrl_q[TC_INIT]; // see (R15)
    assign FSM_RUN  = tbi_ctrl_q[TC_ENABLE] && !tbi_ctrl_q[TC_INIT]; // see (R14)

    // ==========================================================
    // Carrier extension tracker: /T/ /R/ /R/ then comma
    logic [1:0] ext_st_q;
    logic       ext_q;
    logic       is_t, is_r, is_comma;
    assign is_t     = (DEC_CODE_GROUP == CG_T_RDN) || (DEC_CODE_GROUP == CG_T_RDP);
    assign is_r     = (DEC_CODE_GROUP == CG_R_RDN) || (DEC_CODE_GROUP == CG_R_RDP);
    assign is_comma = (DEC_CODE_GROUP[9:3] == COMMA_PAT) || (DEC_CODE_GROUP[9:3] == ~COMMA_PAT);
    always_ff @(posedge CLK)
    begin
        if (RESET || FSM_INIT)
        begin
            ext_st_q <= 2'd0;
            ext_q    <= 1'b0;
        end
        else if (FSM_RUN)
        begin
            ext_q <= 1'b0;
            if (is_t)
                ext_st_q <= 2'd1;
            else if (is_r && ext_st_q != 2'd0 && ext_st_q != 2'd3)
                ext_st_q <= ext_st_q + 2'd1;
            else if (is_comma && ext_st_q == 2'd3)
            begin
                ext_st_q <= 2'd0;
                ext_q    <= tbi_ctrl_q[TC_EXTEND]; // see (R10)
            end
            else
                ext_st_q <= 2'd0;
        end
    end

    // Carrier sense; repeater ignores transmit activity
    always_ff @(posedge CLK)
    begin
        if (RESET || tbi_ctrl_q[TC_CRS_OFF]) // see (R09)
            GMII_CRS <= 1'b0;
        else if (tbi_ctrl_q[TC_REPEATER])
            GMII_CRS <= RX_ACTIVE || ext_q; // see (R11)
        else
            GMII_CRS <= RX_ACTIVE || TX_ACTIVE || ext_q;
    end

endmodule : pcs_ctrl

`default_nettype wire

// >>> bench/pcs_ctrl_sva.sv
/*
 Checker for the TBI control block, bound to its top ports.
 Assumes Avalon writes land at the edge that samples waitrequest low.
*/
`timescale 1ns/10ps
`default_nettype none
module pcs_ctrl_sva
    import pcs_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET,
    // Register bus
    input wire logic [17:0] AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    // Datapath
    input wire logic [9:0]  ENC_CODE_GROUP,
    input wire logic [9:0]  PMA_RX_CODE_GROUP,
    input wire logic [9:0]  PMA_TX_CODE_GROUP,
    input wire logic [9:0]  DEC_CODE_GROUP,
    input wire logic        TX_ACTIVE,
    input wire logic        RX_ACTIVE,
    input wire logic        GMII_CRS,
    input wire logic        FSM_RUN,
    input wire logic        FSM_INIT,
    input wire logic        LOOPBACK_EN,
    input wire logic        NEG_RESTART,
    input wire logic        NEG_FSM_RESTARTED
);
    // ==========================================================
    // Shadow of the TBI control register
    logic [7:0] tc_q;
    wire logic  tbi_hit = AVS_ADDRESS[17:2] == TBI_CTRL_IDX && !AVS_WAITREQUEST;

    function automatic logic [9:0] rev(input logic [9:0] x);
        for (int i = 0; i < 10; i++)
            rev[i] = x[9 - i];
    endfunction : rev

    // Tracks the register only through completed writes
    always_ff @(posedge CLK)
    begin
        if (RESET)
            tc_q <= TBI_CTRL_RST;
        else if (AVS_WRITE && tbi_hit && AVS_BYTEENABLE[0])
            tc_q <= AVS_WRITEDATA[7:0];
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // ==========================================================
    // Assertions
    chk_wait_once: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus answer late");
    chk_tbi_read: assert property (AVS_READ && tbi_hit |-> AVS_READDATA[7:0] == tc_q)
        else $error("tbi readback wrong");
    chk_gate_mirror: assert property (FSM_INIT == tc_q[0] && LOOPBACK_EN == tc_q[2]
        && FSM_RUN == (tc_q[1] && !tc_q[0])) else $error("fsm gating wrong");
    chk_out_rev: assert property (!$past(RESET) |-> PMA_TX_CODE_GROUP ==
        ($past(tc_q[7]) ? rev($past(ENC_CODE_GROUP)) : $past(ENC_CODE_GROUP))) else $error("tx order wrong");
    chk_in_rev: assert property (!$past(RESET) && !$past(tc_q[2]) |-> DEC_CODE_GROUP ==
        ($past(tc_q[6]) ? rev($past(PMA_RX_CODE_GROUP)) : $past(PMA_RX_CODE_GROUP))) else $error("rx order wrong");
    chk_crs_off: assert property (!$past(RESET) && $past(tc_q[5]) |-> !GMII_CRS)
        else $error("crs not off");
    chk_crs_src: assert property (!$past(RESET) && $past(tc_q[5:4]) == 2'h0 |-> GMII_CRS ==
        ($past(RX_ACTIVE) || !$past(tc_q[3]) && $past(TX_ACTIVE))) else $error("crs source wrong");
    chk_restart_drop: assert property (NEG_FSM_RESTARTED && !AVS_WRITE |-> ##[1:3] !NEG_RESTART)
        else $error("restart not cleared");

    // Main scenarios reached
    cov_restart: cover property (NEG_RESTART && NEG_FSM_RESTARTED);
    cov_rev: cover property (tc_q[7] && tc_q[6] && FSM_RUN);
    cov_rpt: cover property (tc_q[3] && TX_ACTIVE);
    cov_ext: cover property (tc_q[4] && GMII_CRS && !RX_ACTIVE && !TX_ACTIVE);
endmodule : pcs_ctrl_sva

bind pcs_ctrl pcs_ctrl_sva chk (.*);
`default_nettype wire

// >>> bench/pcs_far_model.sv
/*
 Far side model: negotiation engine restart handshake and PMA receive lane.
 Assumes the same clock as the control block.
*/
`timescale 1ns/10ps
`default_nettype none
module pcs_far_model
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Engine handshake
    input  wire logic       neg_restart,
    output logic            restarted,
    // PMA receive code groups
    output logic      [9:0] rx_cg
);
    // Engine reports the restart one cycle after seeing the request
    always_ff @(posedge clk)
    begin
        restarted <= !rst && neg_restart && !restarted;
    end

    // Lane never holds still, so a stale value cannot pass for a match
    always_ff @(posedge clk)
    begin
        rx_cg <= rst ? 10'h0f3 : {rx_cg[8:0], ~rx_cg[9]};
    end
endmodule : pcs_far_model
`default_nettype wire

// >>> bench/tb.sv
/*
 Self-checking bench for the TBI control block with short link timers.
 Assumes the far side model and the bound checker are compiled with it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pcs_ctrl_pkg::*;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [17:0] adr = 18'h0;
    logic        rd = 1'h0;
    logic        wr = 1'h0;
    logic [31:0] wd = 32'h0;
    logic [4:0]  ab = 5'h17;
    logic [1:0]  pin = 2'h3;
    logic        en_in = 1'h1;
    logic        rs_in = 1'h0;
    logic [9:0]  enc = 10'h0;
    logic        tx_act = 1'h0;
    logic        rx_act = 1'h0;
    logic [31:0] rdv;
    int          bad_count = 0;
    int          samples_checked = 0;
    wire logic [31:0] rdat;
    wire logic [15:0] cfg;
    wire logic [9:0]  pma_rx, pma_tx, dec;
    wire logic [1:0]  resp, proto;
    wire logic        wrq, rsd, neg_en, neg_rs, tdone, crs, run, init, lpb, bcomp;

    // ==========================================================
    // Clock, device and far side
    always #12.5 clk = !clk;

    pcs_ctrl #(.SIM_CYC(8), .SGMII_CYC(16), .MID_CYC(32), .TBI_CYC(64)) uut (
        .CLK(clk), .RESET(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wrq),
        .AVS_RESPONSE(resp), .FULL_DUPLEX_ABILITY_IN(ab[4]), .HALF_DUPLEX_ABILITY_IN(ab[3]),
        .SPEED_ABILITY_IN(ab[2]), .PAUSE_ABILITY_IN(ab[1]), .REMOTE_FAULT_IN(ab[0]),
        .PROTOCOL_IN(pin), .NEG_ENABLE_IN(en_in), .NEG_RESTART_IN(rs_in), .NEG_FSM_RESTARTED(rsd),
        .TX_CONFIG_WORD(cfg), .NEG_PROTOCOL(proto), .NEG_ENABLE(neg_en), .NEG_RESTART(neg_rs),
        .NEG_LINK_TIMER_DONE(tdone), .NEG_BACKCOMPAT(bcomp), .ENC_CODE_GROUP(enc),
        .PMA_RX_CODE_GROUP(pma_rx), .PMA_TX_CODE_GROUP(pma_tx), .DEC_CODE_GROUP(dec),
        .TX_ACTIVE(tx_act), .RX_ACTIVE(rx_act), .GMII_CRS(crs), .FSM_RUN(run),
        .FSM_INIT(init), .LOOPBACK_EN(lpb));

    pcs_far_model far (.clk(clk), .rst(rst), .neg_restart(neg_rs), .restarted(rsd), .rx_cg(pma_rx));

    // ==========================================================
    // Shared tasks
    task automatic bus(input logic w, input logic [15:0] i, input logic [15:0] d);
        @(posedge clk);
        adr <= {i, 2'h0};
        wd <= {16'h0, d};
        rd <= !w;
        wr <= w;
        // Hold everything until the edge that samples waitrequest low; data taken there
        do
            @(posedge clk);
        while (wrq !== 1'h0);
        rdv = rdat;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask : bus

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : tick

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        bus(1'h0, TBI_CTRL_IDX, 16'h0);
        chk(rdv[15:0], 16'h0001);
        bus(1'h0, NEG_CTRL_IDX, 16'h0);
        chk(rdv[15:0], 16'h00b2);
        chk(16'(bcomp), 16'h0);
        chk(16'({run, init}), 16'h1);
        bus(1'h0, 16'h0100, 16'h0);
        chk(rdv[15:0], 16'h0);
        chk(16'(resp), 16'h2);
        $display("reset test done");
    endtask : t_reset

    task automatic t_rev;
        logic [9:0] e;
        bus(1'h1, TBI_CTRL_IDX, 16'h00c2);
        bus(1'h0, TBI_CTRL_IDX, 16'h0);
        chk(rdv[15:0], 16'h00c2);
        @(posedge clk);
        enc <= 10'h17c;
        tick(1);
        e = {<<{10'h17c}};
        chk(16'(pma_tx), 16'(e));
        e = {<<{pma_rx}};
        tick(1);
        chk(16'(dec), 16'(e));
        chk(16'({run, init}), 16'h2);
        bus(1'h1, TBI_CTRL_IDX, 16'h0002);
        tick(0);
        e = pma_rx;
        tick(1);
        chk(16'(dec), 16'(e));
        chk(16'(pma_tx), 16'h017c);
        bus(1'h1, TBI_CTRL_IDX, 16'h0000);
        tick(0);
        chk(16'({run, init}), 16'h0);
        $display("reversal test done");
    endtask : t_rev

    task automatic t_crs;
        logic [15:0] m [3] = '{16'h0002, 16'h000a, 16'h0022};
        logic [5:0]  x = 6'h0b;
        for (int k = 0; k < 3; k++)
        begin
            bus(1'h1, TBI_CTRL_IDX, m[k]);
            for (int a = 0; a < 2; a++)
            begin
                @(posedge clk);
                tx_act <= !a[0];
                rx_act <= a[0];
                tick(1);
                chk(16'(crs), 16'(x[k * 2 + a]));
            end
        end
        @(posedge clk);
        rx_act <= 1'h0;
        $display("carrier sense test done");
    endtask : t_crs

    task automatic t_loop;
        bus(1'h1, TBI_CTRL_IDX, 16'h0006);
        @(posedge clk);
        enc <= 10'h2aa;
        tick(3);
        chk(16'(dec), 16'h02aa);
        chk(16'(lpb), 16'h1);
        bus(1'h1, TBI_CTRL_IDX, 16'h0002);
        $display("loopback test done");
    endtask : t_loop

    task automatic t_ext;
        logic [9:0] g [4] = '{CG_T_RDN, CG_R_RDN, CG_R_RDN, {COMMA_PAT, 3'h2}};
        for (int s = 1; s >= 0; s--)
        begin
            // Loopback carries /T/ /R/ /R/ comma to the tracker; CRS pulses only if selected
            bus(1'h1, TBI_CTRL_IDX, s ? 16'h0016 : 16'h0006);
            for (int k = 0; k < 4; k++)
            begin
                @(posedge clk);
                enc <= g[k];
            end
            tick(4);
            chk(16'(crs), 16'(s));
            tick(1);
            chk(16'(crs), 16'h0);
        end
        bus(1'h1, TBI_CTRL_IDX, 16'h0002);
        $display("carrier extension test done");
    endtask : t_ext

    task automatic t_neg;
        logic [15:0] c [4] = '{16'h00b5, 16'h0065, 16'h0065, 16'h00a5};
        logic [4:0]  b [4] = '{5'h17, 5'h17, 5'h08, 5'h17};
        logic [15:0] e [4] = '{16'ha55a, 16'h31a0, 16'h0040, 16'h1801};
        bus(1'h1, TX_WORD_HI_IDX, 16'h00a5);
        bus(1'h1, TX_WORD_LO_IDX, 16'h005a);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            ab <= b[k];
            bus(1'h1, NEG_CTRL_IDX, c[k]);
            tick(6);
            chk(cfg, e[k]);
            chk(16'(proto), 16'(c[k][7:6]));
            chk(16'(neg_en), 16'h1);
        end
        bus(1'h1, NEG_CTRL_IDX, 16'h006d);
        tick(5);
        chk(16'(neg_rs), 16'h0);
        bus(1'h0, NEG_CTRL_IDX, 16'h0);
        chk(rdv[15:0], 16'h0065);
        bus(1'h0, STATUS_IDX, 16'h0);
        chk(rdv[15:0], 16'h0005);
        bus(1'h1, NEG_CTRL_IDX, 16'h0061);
        tick(2);
        chk(16'(neg_en), 16'h0);
        bus(1'h1, NEG_CTRL_IDX, 16'h8041);
        tick(6);
        chk(16'(proto), 16'h3);
        chk(16'(neg_en), 16'h1);
        chk(16'(bcomp), 16'h1);
        // Pin controls in hardware mode: levels and a one-cycle restart pulse
        @(posedge clk);
        pin <= 2'h1;
        en_in <= 1'h0;
        rs_in <= 1'h1;
        @(posedge clk);
        rs_in <= 1'h0;
        tick(2);
        chk(16'(neg_rs), 16'h1);
        tick(1);
        chk(16'(neg_rs), 16'h0);
        chk(16'(proto), 16'h1);
        chk(16'(neg_en), 16'h0);
        $display("negotiation test done");
    endtask : t_neg

    task automatic t_timer;
        int n;
        int lim [4] = '{8, 16, 32, 64};
        for (int s = 0; s < 4; s++)
        begin
            bus(1'h1, NEG_CTRL_IDX, 16'h0064 | 16'(s));
            do @(negedge clk); while (tdone !== 1'h1);
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end while (tdone !== 1'h1);
            chk(16'(n), 16'(lim[s]));
        end
        $display("link timer test done");
    endtask : t_timer

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_rev();
        t_crs();
        t_loop();
        t_ext();
        t_neg();
        t_timer();
        report_and_stop();
    end

    initial
    begin
        #200000;
        bad_count++;
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
